//--- rtl/fws_pkg.sv
// Constants, types and field layouts for the floppy write/format sequencer.
// Assumes one 40 MHz clock shared with the host side and the drive side logic.
// Contract
// - Load head, settle, then scan IDs
// - Write only when four ID bytes match
// - Increment slot_index per sector until terminal_count
// - Terminal count mid-field pads zeros
// - ID CRC error sets id_crc_error, aborts
// - Late host byte sets overrun, aborts; code times write data bytes only, format ID bytes never overrun
// - Write-deleted uses deleted data mark
// - Read-deleted normal mark: skip or control_flag
// - Read-track from index, ignore CRC errors
// - Read-track mismatch sets no_data_flag; no options
// - Read-track ends at final_sector count
// - Read-track second index without ID aborts
// - Read-ID captures first readable ID
// - Read-ID second index sets absent flags
// - Format starts at index with parameters
// - Format data field is fill_pattern
// - Format requests four ID bytes per sector
// - Format increments slot, ends second index
// - Unchanged result bytes equal start values
// - Side change inverts side_number LSB only
// - size_code zero limits transfer to short_length
package fws_pkg;
    localparam int unsigned FWS_CLK_HZ = 40_000_000;
    localparam int unsigned FWS_FM_LIMIT_US = 27;
    localparam int unsigned FWS_MFM_LIMIT_US = 13;
    // Longest times round down
    localparam int unsigned FWS_FM_LIMIT_CYC = FWS_FM_LIMIT_US * (FWS_CLK_HZ / 1_000_000);
    localparam int unsigned FWS_MFM_LIMIT_CYC = FWS_MFM_LIMIT_US * (FWS_CLK_HZ / 1_000_000);
    localparam int unsigned FWS_SETTLE_DEF = 4000;
    localparam int unsigned FWS_CMD_BYTES = 9;
    localparam logic [10:0] FWS_TMR_RESET = 11'h000;
    localparam logic [7:0] FWS_BYTE_RESET = 8'h00;
    localparam logic [7:0] FWS_PAD_BYTE = 8'h00;
    localparam int unsigned FWS_ST0_IC_HI = 7;
    localparam int unsigned FWS_ST0_IC_LO = 6;
    localparam logic [1:0] FWS_IC_NORMAL = 2'b00;
    localparam logic [1:0] FWS_IC_ABNORMAL = 2'b01;

    typedef enum logic [2:0] {
        FWS_OP_WRITE, FWS_OP_WRITE_DEL, FWS_OP_READ_DEL,
        FWS_OP_READ_TRACK, FWS_OP_READ_ID, FWS_OP_FORMAT
    } fws_op_e;

    typedef struct packed {
        logic [7:0] radial_position;
        logic [7:0] side_number;
        logic [7:0] slot_index;
        logic [7:0] size_code;
    } fws_id_s;

    typedef struct packed {
        fws_op_e op;
        logic mfm;
        logic skip_flag;
        logic two_side_option;
        fws_id_s id;
        logic [7:0] final_sector;
        logic [7:0] short_length;
        logic [7:0] sectors_per_track;
        logic [7:0] gap3_length;
        logic [7:0] fill_pattern;
    } fws_cmd_s;

    typedef struct packed {
        logic [7:0] st0;
        logic [7:0] st1;
        logic [7:0] st2;
        fws_id_s id;
    } fws_result_s;

    // Status bit positions
    localparam int unsigned FWS_ST1_ABSENT = 0;
    localparam int unsigned FWS_ST1_NODATA = 2;
    localparam int unsigned FWS_ST1_OVERRUN = 4;
    localparam int unsigned FWS_ST1_CRC = 5;
    localparam int unsigned FWS_ST2_CONTROL = 6;

    function automatic logic [15:0] fws_sector_len(input logic [7:0] size_code,
                                                   input logic [7:0] short_length);
        if (size_code == 8'h00) begin
            return {8'h00, short_length};
        end
        return 16'h0080 << size_code[2:0];
    endfunction : fws_sector_len
endpackage : fws_pkg

//--- rtl/fws_sequencer.sv
// Execution-phase sequencer: drive field events in, byte stream to and from host.
// Assumes command bytes are already parsed into a command struct by the caller.
`timescale 1ns/1ps
module fws_sequencer
    import fws_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = FWS_SETTLE_DEF
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire fws_cmd_s cmd_i,
    input wire logic cmd_count_ok_i,
    input wire logic head_loaded_i,
    input wire logic index_i,
    input wire logic id_valid_i,
    input wire fws_id_s id_i,
    input wire logic id_crc_bad_i,
    input wire logic data_mark_i,
    input wire logic data_mark_deleted_i,
    input wire logic data_crc_bad_i,
    input wire logic disk_byte_req_i,
    input wire logic [7:0] disk_byte_i,
    input wire logic field_done_i,
    input wire logic host_ack_i,
    input wire logic [7:0] host_data_i,
    input wire logic terminal_count,
    output logic head_load_o,
    output logic host_req_o,
    output logic [7:0] host_data_o,
    output logic disk_we_o,
    output logic [7:0] disk_data_o,
    output logic deleted_mark_o,
    output logic busy_o,
    output logic done_o,
    output fws_result_s result_o
);
    typedef enum logic [2:0] {
        S_IDLE, S_SETTLE, S_SCAN, S_DATA, S_FMT_ID, S_END
    } fws_state_e;

    localparam logic [10:0] FM_LIM = 11'(FWS_FM_LIMIT_CYC);
    localparam logic [10:0] MFM_LIM = 11'(FWS_MFM_LIMIT_CYC);

    fws_state_e state_reg;
    fws_cmd_s cmd_reg;
    fws_id_s start_id_reg;
    fws_id_s cur_id_reg;
    logic [7:0] st1_reg;
    logic [7:0] st2_reg;
    logic abort_reg;
    logic [1:0] index_cnt_reg;
    logic id_seen_reg;
    logic tc_reg;
    logic [15:0] byte_cnt_reg;
    logic [7:0] sect_cnt_reg;
    logic [1:0] fmt_idx_reg;
    logic [31:0] settle_reg;
    logic [10:0] tmr_reg;
    logic wait_host_reg;
    logic side_flip_reg;

    wire logic is_write = (cmd_reg.op == FWS_OP_WRITE) || (cmd_reg.op == FWS_OP_WRITE_DEL);
    wire logic is_fmt = (cmd_reg.op == FWS_OP_FORMAT);
    wire logic id_match = (id_i == cur_id_reg);
    wire logic [15:0] xfer_len = fws_sector_len(cur_id_reg.size_code, cmd_reg.short_length);
    wire logic [10:0] limit = cmd_reg.mfm ? MFM_LIM : FM_LIM;
    wire logic overrun = wait_host_reg && (tmr_reg >= limit);
    wire logic last_sector = (cur_id_reg.slot_index == cmd_reg.final_sector);

    assign busy_o = (state_reg != S_IDLE);
    assign done_o = (state_reg == S_END);
    assign head_load_o = busy_o;
    assign deleted_mark_o = (cmd_reg.op == FWS_OP_WRITE_DEL);
    assign host_req_o = wait_host_reg;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= S_IDLE;
            cmd_reg <= '0;
            start_id_reg <= '0;
            cur_id_reg <= '0;
            st1_reg <= FWS_BYTE_RESET;
            st2_reg <= FWS_BYTE_RESET;
            abort_reg <= 1'b0;
            index_cnt_reg <= 2'd0;
            id_seen_reg <= 1'b0;
            tc_reg <= 1'b0;
            byte_cnt_reg <= 16'h0000;
            sect_cnt_reg <= FWS_BYTE_RESET;
            fmt_idx_reg <= 2'd0;
            settle_reg <= 32'h0;
            side_flip_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    if (start_i && cmd_count_ok_i) begin
                        cmd_reg <= cmd_i;
                        start_id_reg <= cmd_i.id;
                        cur_id_reg <= cmd_i.id;
                        st1_reg <= FWS_BYTE_RESET;
                        st2_reg <= FWS_BYTE_RESET;
                        abort_reg <= 1'b0;
                        index_cnt_reg <= 2'd0;
                        id_seen_reg <= 1'b0;
                        tc_reg <= 1'b0;
                        sect_cnt_reg <= FWS_BYTE_RESET;
                        fmt_idx_reg <= 2'd0;
                        side_flip_reg <= 1'b0;
                        settle_reg <= head_loaded_i ? 32'h0 : 32'(SETTLE_CYC);
                        state_reg <= S_SETTLE;
                    end
                end
                S_SETTLE: begin
                    if (settle_reg != 32'h0) begin
                        settle_reg <= settle_reg - 32'h1;
                    end else begin
                        state_reg <= S_SCAN;
                    end
                end
                S_SCAN: begin
                    if (index_i) begin
                        index_cnt_reg <= index_cnt_reg + 2'd1;
                    end
                    if (is_fmt) begin
                        if (index_i) begin
                            fmt_idx_reg <= 2'd0;
                            state_reg <= S_FMT_ID;
                        end
                    end else if (index_i && index_cnt_reg == 2'd1 && !id_seen_reg) begin
                        st1_reg[FWS_ST1_ABSENT] <= 1'b1;
                        if (cmd_reg.op == FWS_OP_READ_ID) begin
                            st1_reg[FWS_ST1_NODATA] <= 1'b1;
                        end
                        abort_reg <= 1'b1;
                        state_reg <= S_END;
                    end else if (index_i && index_cnt_reg == 2'd1 && is_write) begin
                        st1_reg[FWS_ST1_NODATA] <= 1'b1;
                        abort_reg <= 1'b1;
                        state_reg <= S_END;
                    end else if (id_valid_i) begin
                        id_seen_reg <= 1'b1;
                        if (cmd_reg.op == FWS_OP_READ_ID) begin
                            if (!id_crc_bad_i) begin
                                cur_id_reg <= id_i;
                                state_reg <= S_END;
                            end
                        end else if (cmd_reg.op == FWS_OP_READ_TRACK) begin
                            if (index_cnt_reg != 2'd0) begin
                                if (!id_match) begin
                                    st1_reg[FWS_ST1_NODATA] <= 1'b1;
                                end
                                byte_cnt_reg <= 16'h0000;
                                state_reg <= S_DATA;
                            end
                        end else if (id_crc_bad_i) begin
                            st1_reg[FWS_ST1_CRC] <= 1'b1;
                            abort_reg <= 1'b1;
                            state_reg <= S_END;
                        end else if (id_match) begin
                            byte_cnt_reg <= 16'h0000;
                            state_reg <= S_DATA;
                        end
                    end
                end
                S_DATA: begin
                    if (terminal_count && !is_fmt) begin
                        tc_reg <= 1'b1;
                    end
                    if (overrun) begin
                        st1_reg[FWS_ST1_OVERRUN] <= 1'b1;
                        abort_reg <= 1'b1;
                        state_reg <= S_END;
                    end else if (data_mark_i && cmd_reg.op == FWS_OP_READ_DEL
                                 && !data_mark_deleted_i) begin
                        // Normal mark follows the matched ID
                        if (cmd_reg.skip_flag) begin
                            cur_id_reg.slot_index <= cur_id_reg.slot_index + 8'h01;
                            state_reg <= S_SCAN;
                        end else begin
                            st2_reg[FWS_ST2_CONTROL] <= 1'b1;
                        end
                    end else if (disk_byte_req_i) begin
                        byte_cnt_reg <= byte_cnt_reg + 16'h1;
                    end else if (field_done_i) begin
                        sect_cnt_reg <= sect_cnt_reg + 8'h01;
                        cur_id_reg.slot_index <= cur_id_reg.slot_index + 8'h01;
                        if (is_fmt) begin
                            state_reg <= S_FMT_ID;
                            fmt_idx_reg <= 2'd0;
                        end else if (cmd_reg.op == FWS_OP_READ_TRACK) begin
                            if (sect_cnt_reg + 8'h01 == cmd_reg.final_sector) begin
                                state_reg <= S_END;
                            end else begin
                                state_reg <= S_SCAN;
                            end
                        end else if (cmd_reg.op == FWS_OP_READ_DEL && st2_reg[FWS_ST2_CONTROL]) begin
                            state_reg <= S_END;
                        end else if (tc_reg || terminal_count) begin
                            if (last_sector) begin
                                cur_id_reg.slot_index <= 8'h01;
                                if (cmd_reg.two_side_option) begin
                                    side_flip_reg <= 1'b1;
                                end else begin
                                    cur_id_reg.radial_position <= cur_id_reg.radial_position + 8'h01;
                                end
                            end
                            state_reg <= S_END;
                        end else begin
                            state_reg <= S_SCAN;
                        end
                    end
                end
                S_FMT_ID: begin
                    if (index_i) begin
                        state_reg <= S_END;
                    end else if (host_ack_i) begin
                        unique case (fmt_idx_reg)
                            2'd0: cur_id_reg.radial_position <= host_data_i;
                            2'd1: cur_id_reg.side_number <= host_data_i;
                            2'd2: cur_id_reg.slot_index <= host_data_i;
                            2'd3: cur_id_reg.size_code <= host_data_i;
                        endcase
                        fmt_idx_reg <= fmt_idx_reg + 2'd1;
                        if (fmt_idx_reg == 2'd3) begin
                            byte_cnt_reg <= 16'h0000;
                            state_reg <= S_DATA;
                        end
                    end
                end
                S_END: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Host byte wait timer for overrun
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_host_reg <= 1'b0;
            tmr_reg <= FWS_TMR_RESET;
        end else if (state_reg == S_FMT_ID && !wait_host_reg) begin
            wait_host_reg <= 1'b1;
            tmr_reg <= FWS_TMR_RESET;
        end else if (state_reg == S_DATA && is_write && !tc_reg && !terminal_count
                     && disk_byte_req_i && byte_cnt_reg < xfer_len && !wait_host_reg) begin
            wait_host_reg <= 1'b1;
            tmr_reg <= FWS_TMR_RESET;
        end else if (host_ack_i || state_reg == S_END || state_reg == S_IDLE) begin
            wait_host_reg <= 1'b0;
            tmr_reg <= FWS_TMR_RESET;
        end else if (wait_host_reg && is_write) begin
            tmr_reg <= tmr_reg + 11'h1;
        end
    end

    // Drive side data and read-out to host
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            disk_we_o <= 1'b0;
            disk_data_o <= FWS_PAD_BYTE;
            host_data_o <= FWS_BYTE_RESET;
        end else begin
            disk_we_o <= (state_reg == S_DATA) && (is_write || is_fmt) && disk_byte_req_i;
            if (state_reg == S_DATA && disk_byte_req_i) begin
                if (is_fmt) begin
                    disk_data_o <= cmd_reg.fill_pattern;
                end else if (tc_reg || terminal_count || byte_cnt_reg >= xfer_len) begin
                    disk_data_o <= FWS_PAD_BYTE;
                end else begin
                    disk_data_o <= host_data_i;
                end
                if (!is_write && byte_cnt_reg < xfer_len) begin
                    host_data_o <= disk_byte_i;
                end
            end
        end
    end

    // Result: untouched bytes keep start values
    always_comb begin
        result_o.st0 = FWS_BYTE_RESET;
        result_o.st0[FWS_ST0_IC_HI:FWS_ST0_IC_LO] =
            abort_reg ? FWS_IC_ABNORMAL : FWS_IC_NORMAL;
        result_o.st1 = st1_reg;
        result_o.st2 = st2_reg;
        result_o.id = cur_id_reg;
        result_o.id.side_number = {start_id_reg.side_number[7:1],
            start_id_reg.side_number[0] ^ side_flip_reg};
        if (cmd_reg.op == FWS_OP_READ_ID) begin
            result_o.id.side_number = cur_id_reg.side_number;
        end
    end

    a_abort_code: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        done_o |-> (result_o.st0[7:6] == (abort_reg ? 2'b01 : 2'b00)))
        else $error("status code mismatch");
    a_crc_abort: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_reg == S_SCAN && is_write && id_valid_i && id_crc_bad_i && !index_i)
        |=> (state_reg == S_END && st1_reg[FWS_ST1_CRC]))
        else $error("crc abort missing");
    a_overrun_end: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_reg == S_DATA && overrun) |=> (state_reg == S_END && st1_reg[FWS_ST1_OVERRUN]))
        else $error("overrun not flagged");
    a_fill_byte: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_reg == S_DATA && is_fmt && disk_byte_req_i) |=> (disk_data_o == cmd_reg.fill_pattern))
        else $error("format fill wrong");
    a_slot_step: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_reg == S_DATA && field_done_i && !overrun && !disk_byte_req_i && is_write
         && !tc_reg && !terminal_count)
        |=> (cur_id_reg.slot_index == $past(cur_id_reg.slot_index) + 8'h01))
        else $error("slot not advanced");
    a_match_gate: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ($rose(state_reg == S_DATA) && is_write) |-> $past(id_match))
        else $error("write without id match");
    a_pad_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_reg == S_DATA && is_write && tc_reg && disk_byte_req_i) |=> (disk_data_o == 8'h00))
        else $error("pad not zero");
    a_fmt_end: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_reg == S_FMT_ID && index_i) |=> (state_reg == S_END))
        else $error("format did not end");
endmodule : fws_sequencer

//--- verification/fws_drive_model.sv
// Behavioural drive: index pulse, ID fields and data field byte slots, one track per pass.
// Assumes the bench holds run_i high for the length of one command.
`timescale 1ns/1ps
module fws_drive_model
    import fws_pkg::*;
#(
    parameter int unsigned NBYTES = 4
) (
    input wire logic core_clk_i,
    input wire logic run_i,
    input wire fws_id_s base_i,
    input wire logic crc_bad_i,
    output logic index_o,
    output logic id_valid_o,
    output fws_id_s id_o,
    output logic id_crc_bad_o,
    output logic data_mark_o,
    output logic byte_req_o,
    output logic [7:0] byte_o,
    output logic field_done_o
);
    initial begin
        {index_o, id_valid_o, id_crc_bad_o, data_mark_o, byte_req_o, field_done_o} = '0;
        id_o = '0;
        byte_o = 8'h5a;
        forever begin
            @(posedge core_clk_i);
            byte_o <= ~byte_o;
            if (run_i) begin
                index_o <= 1'b1;
                @(posedge core_clk_i);
                index_o <= 1'b0;
                for (int s = 1; s <= 4; s++) begin
                    repeat (20) @(posedge core_clk_i);
                    // Sector numbers run 1..4 on every pass
                    id_o <= '{base_i.radial_position, base_i.side_number, 8'(s), base_i.size_code};
                    id_crc_bad_o <= crc_bad_i;
                    id_valid_o <= 1'b1;
                    @(posedge core_clk_i);
                    id_valid_o <= 1'b0;
                    id_crc_bad_o <= ~crc_bad_i;
                    id_o <= ~id_o;
                    repeat (10) @(posedge core_clk_i);
                    data_mark_o <= 1'b1;
                    @(posedge core_clk_i);
                    data_mark_o <= 1'b0;
                    for (int b = 0; b < NBYTES; b++) begin
                        repeat (40) @(posedge core_clk_i);
                        byte_req_o <= 1'b1;
                        byte_o <= 8'(b * 37 + 3);
                        @(posedge core_clk_i);
                        byte_req_o <= 1'b0;
                        byte_o <= ~byte_o;
                    end
                    repeat (10) @(posedge core_clk_i);
                    field_done_o <= 1'b1;
                    @(posedge core_clk_i);
                    field_done_o <= 1'b0;
                end
            end
        end
    end
endmodule : fws_drive_model

//--- verification/test_fdc_write_format_sequencer.sv
// Self-checking bench: write, write-deleted, ID CRC and overrun aborts, read-ID,
// read-deleted, read-track and format.
// Assumes the drive model above and a 40 MHz clock; inputs change at rising edges.
`timescale 1ns/1ps
module test_fdc_write_format_sequencer
    import fws_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0, run = 1'b0, crc_bad = 1'b0, ack = 1'b0, tc = 1'b0;
    logic [7:0] hdata = 8'h00;
    fws_cmd_s cmd = '0;
    logic index, id_valid, id_crc, dmark, breq, fdone, busy, done, del, hreq, we, hload;
    logic [7:0] dbyte, hout, ddata;
    fws_id_s id_w;
    fws_result_s result, res;
    logic [7:0] wq[$];
    logic del_seen, got_done, head_loaded = 1'b0;
    logic [7:0] hv, fslot;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    logic [31:0] seed = 32'd78343;
    always #12.5 core_clk = ~core_clk;
    fws_drive_model #(.NBYTES(4)) drv (.core_clk_i(core_clk), .run_i(run), .base_i(cmd.id),
        .crc_bad_i(crc_bad), .index_o(index), .id_valid_o(id_valid), .id_o(id_w),
        .id_crc_bad_o(id_crc), .data_mark_o(dmark), .byte_req_o(breq), .byte_o(dbyte),
        .field_done_o(fdone));
    fws_sequencer #(.SETTLE_CYC(4)) uut (.core_clk_i(core_clk), .rstn_i(rstn),
        .start_i(start), .cmd_i(cmd), .cmd_count_ok_i(1'b1), .head_loaded_i(head_loaded),
        .index_i(index), .id_valid_i(id_valid), .id_i(id_w), .id_crc_bad_i(id_crc),
        .data_mark_i(dmark), .data_mark_deleted_i(1'b0), .data_crc_bad_i(1'b0),
        .disk_byte_req_i(breq), .disk_byte_i(dbyte), .field_done_i(fdone),
        .host_ack_i(ack), .host_data_i(hdata), .terminal_count(tc), .head_load_o(hload),
        .host_req_o(hreq), .host_data_o(hout), .disk_we_o(we), .disk_data_o(ddata),
        .deleted_mark_o(del), .busy_o(busy), .done_o(done), .result_o(result));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One command: host answers requests unless told not to, tc from ack number tc_at
    task automatic run_cmd(input fws_op_e op, input int tc_at, input bit answer);
        int n;
        int w;
        n = 0;
        w = 0;
        wq.delete();
        del_seen = 1'b0;
        got_done = 1'b0;
        res = '0;
        cmd.op <= op;
        head_loaded <= rnd() > 32'h7fff_ffff;
        start <= 1'b1;
        run <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        while (got_done !== 1'b1 && w < 8000) begin
            @(negedge core_clk);
            w++;
            if (w == 1) chk("head load", 1, hload && busy);
            if (we === 1'b1) wq.push_back(ddata);
            if (del === 1'b1) del_seen = 1'b1;
            if (done === 1'b1) {got_done, res} = {1'b1, result};
            @(posedge core_clk);
            if (answer && hreq === 1'b1 && ack === 1'b0 && !got_done) begin
                n++;
                hv = 8'(rnd()) | 8'h01;
                hdata <= hv;
                // Slot byte of the fourth formatted sector
                if (n == 15) fslot = hv + 8'h01;
                ack <= 1'b1;
                if (n >= tc_at) tc <= 1'b1;
            end else begin
                ack <= 1'b0;
            end
        end
        chk("done seen", 1, got_done);
        @(posedge core_clk);
        {ack, tc, run} <= '0;
        // Longer than one pass: next command meets an idle drive
        repeat (900) @(posedge core_clk);
    endtask : run_cmd
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        cmd.mfm <= 1'b1;
        cmd.short_length <= 8'h04;
        cmd.final_sector <= 8'h04;
        cmd.fill_pattern <= 8'(rnd());
        cmd.id <= '{8'(rnd()) & 8'h7f, 8'h00, 8'h02, 8'h00};
        @(posedge core_clk);
        // Sector 1 does not match; tc at second byte of sector 2
        run_cmd(FWS_OP_WRITE, 2, 1'b1);
        chk("write byte count", 4, wq.size());
        chk("pad byte 2", FWS_PAD_BYTE, wq.size() > 2 ? wq[2] : 8'hff);
        chk("pad byte 3", FWS_PAD_BYTE, wq.size() > 3 ? wq[3] : 8'hff);
        chk("write st0 ic", FWS_IC_NORMAL, res.st0[7:6]);
        chk("write slot", 8'h03, res.id.slot_index);
        chk("write radial", cmd.id.radial_position, res.id.radial_position);
        chk("write side", cmd.id.side_number, res.id.side_number);
        chk("write no deleted mark", 0, del_seen);
        $display("test write done");
        run_cmd(FWS_OP_WRITE_DEL, 1, 1'b1);
        chk("deleted mark", 1, del_seen);
        $display("test write deleted done");
        crc_bad <= 1'b1;
        run_cmd(FWS_OP_WRITE, 1, 1'b1);
        chk("crc st1", 1, res.st1[FWS_ST1_CRC]);
        chk("crc st0 ic", FWS_IC_ABNORMAL, res.st0[7:6]);
        chk("crc no write", 0, wq.size());
        crc_bad <= 1'b0;
        $display("test id crc done");
        run_cmd(FWS_OP_WRITE, 99, 1'b0);
        chk("overrun st1", 1, res.st1[FWS_ST1_OVERRUN]);
        chk("overrun st0 ic", FWS_IC_ABNORMAL, res.st0[7:6]);
        $display("test overrun done");
        run_cmd(FWS_OP_READ_ID, 99, 1'b1);
        chk("read id", {cmd.id.radial_position, cmd.id.side_number, 8'h01, cmd.id.size_code},
            res.id);
        chk("read id st0 ic", FWS_IC_NORMAL, res.st0[7:6]);
        $display("test read id done");
        run_cmd(FWS_OP_READ_DEL, 99, 1'b1);
        chk("read del control", 1, res.st2[FWS_ST2_CONTROL]);
        chk("read del st0 ic", FWS_IC_NORMAL, res.st0[7:6]);
        chk("read del last byte", 8'h72, hout);
        $display("test read deleted done");
        run_cmd(FWS_OP_READ_TRACK, 99, 1'b1);
        chk("track no data", 1, res.st1[FWS_ST1_NODATA]);
        chk("track st0 ic", FWS_IC_NORMAL, res.st0[7:6]);
        chk("track last byte", 8'h72, hout);
        $display("test read track done");
        run_cmd(FWS_OP_FORMAT, 99, 1'b1);
        chk("format byte count", 16, wq.size());
        foreach (wq[i]) chk("format fill", cmd.fill_pattern, wq[i]);
        chk("format slot", fslot, res.id.slot_index);
        chk("format st0 ic", FWS_IC_NORMAL, res.st0[7:6]);
        $display("test format done");
        stop_test();
    end
endmodule : test_fdc_write_format_sequencer
